// ### logic/ndpc_ctrl.sv
// ndpc_ctrl.sv: apb-programmed host that issues dual-plane and block-protect sequences
// assumes: apb master on mclk_in, nand device on async pins, rb# open drain pulled up
//
// Notes on behaviour
// - both planes get the same operation type
// - software gives planes different plane-select bits
// - software gives both planes same page bits
// - 80h..11h loads cache, 80h..10h writes both
// - 80h..11h then 80h..15h is cache program
// - 85h changes column during data load
// - 60h..D1h then 60h..D0h erases both blocks
// - 23h lower bound then 24h upper bound
// - byte bus: three address cycles, fixed layout
// - word bus: three cycles, upper byte low
// - write-protect high before 2Ch
//
// The implementer's own choices: the address map and the APB interface to the registers.
`default_nettype none
`include "ndpc_consts.svh"
module ndpc_ctrl
  import ndpc_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // nand pins
  output logic ce_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic wp_n_out,
  output logic [15:0] io_o_out,
  output logic io_oe_out,
  input wire logic [15:0] io_i_in,
  input wire logic rb_n_in
);
  // ==========================================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD1 = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_CMD2 = 6'b001000,
    ST_READ = 6'b010000,
    ST_WAIT = 6'b100000
  } ndpc_st_e;
  typedef struct packed {
    ndpc_st_e st;
    logic [31:0] ctrl;      // last order
    logic [31:0] addr1;     // row/col address bytes, lsb first
    logic [7:0] addr2;      // fifth address byte
    logic [2:0] acnt;       // address cycles still to send
    logic [2:0] aidx;
    logic busy, err, go;
    logic [15:0] result;
    logic [15:0] wcnt;
    logic rb_m, rb_s;
    logic pready;
    logic [31:0] prdata;
    logic wp_n;
    logic [7:0] pend;       // program tail held until the next non-data order
    logic resume;           // pending tail goes first, then the new order
  } ndpc_ctl_s;
  ndpc_ctl_s s_r, s_nxt;
  // cycle engine hookup
  ndpc_lane_e cyc_kind;
  logic [15:0] cyc_byte;
  logic cyc_done;
  logic [15:0] cyc_rd;
  logic cyc_io_oe;
  logic [15:0] cyc_io;
  logic cyc_cle, cyc_ale, cyc_we, cyc_re;
  ndpc_op_e op;
  logic x16;
  // ==========================================================================
  // helpers
  // first command byte of an opcode
  function automatic logic [7:0] first_cmd(input ndpc_op_e o);
    unique case (o)
      NDPC_OP_PROG_MID, NDPC_OP_PROG_END, NDPC_OP_CACHE_END: first_cmd = `NDPC_CMD_PROG;
      NDPC_OP_RAND_IN: first_cmd = `NDPC_CMD_RAND_IN;
      NDPC_OP_ERASE_MID, NDPC_OP_ERASE_END: first_cmd = `NDPC_CMD_ERASE;
      NDPC_OP_UNP_LO: first_cmd = `NDPC_CMD_UNP_LO;
      NDPC_OP_UNP_HI: first_cmd = `NDPC_CMD_UNP_HI;
      NDPC_OP_PROTECT: first_cmd = `NDPC_CMD_PROTECT;
      NDPC_OP_SOLID: first_cmd = `NDPC_CMD_SOLID;
      NDPC_OP_PSTAT: first_cmd = `NDPC_CMD_PSTAT;
      NDPC_OP_STATUS: first_cmd = `NDPC_CMD_STATUS;
      NDPC_OP_STAT_ENH: first_cmd = `NDPC_CMD_STAT_ENH;
      default: first_cmd = 8'h00;
    endcase
  endfunction : first_cmd
  // number of address cycles an opcode carries
  function automatic logic [2:0] addr_cycles(input ndpc_op_e o);
    unique case (o)
      NDPC_OP_PROG_MID, NDPC_OP_PROG_END, NDPC_OP_CACHE_END: addr_cycles = 3'd5;
      NDPC_OP_RAND_IN: addr_cycles = 3'd2;
      NDPC_OP_ERASE_MID, NDPC_OP_ERASE_END: addr_cycles = 3'd3;
      NDPC_OP_UNP_LO, NDPC_OP_UNP_HI, NDPC_OP_PSTAT: addr_cycles = 3'd3;
      default: addr_cycles = 3'd0;
    endcase
  endfunction : addr_cycles
  assign op = ndpc_op_e'(s_r.ctrl[`NDPC_CTRL_OP_LSB +: 4]);
  assign x16 = s_r.ctrl[`NDPC_CTRL_X16_BIT];
  // ==========================================================================
  // sequencer and apb slave
  always_comb
  begin
    logic [7:0] ab;
    logic [7:0] ctail;
    ab = 8'h00;
    ctail = 8'h00;
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.pready = 1'b0;
    // rb# crosses from the device: two flops, only rb_s is read
    s_nxt.rb_m = rb_n_in;
    s_nxt.rb_s = s_r.rb_m;
    cyc_kind = NDPC_LANE_CMD;
    cyc_byte = 16'h0000;
    // apb: one wait state, answer in the access phase's second cycle
    if (psel_in && penable_in && !s_r.pready)
    begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      if (pwrite_in)
      begin
        unique case (paddr_in)
          `NDPC_OFF_CTRL:
          begin
            // orders are refused while busy; software polls status
            if (!s_r.busy)
            begin
              s_nxt.ctrl = pwdata_in;
              s_nxt.busy = 1'b1;
              s_nxt.err = 1'b0;
              s_nxt.st = ST_CMD1;
              s_nxt.go = 1'b1;
              // an open program load is closed by the next order that is not data
              if ((s_r.pend != 8'h00) && (pwdata_in[3:0] != NDPC_OP_DATA) &&
                  (pwdata_in[3:0] != NDPC_OP_RAND_IN))
              begin
                s_nxt.st = ST_CMD2;
                s_nxt.resume = 1'b1;
              end
              // 2Ch needs write-protect released; lift it before the command
              s_nxt.wp_n = 1'b1;
            end
          end
          `NDPC_OFF_ADDR1: s_nxt.addr1 = pwdata_in;
          `NDPC_OFF_ADDR2: s_nxt.addr2 = pwdata_in[7:0];
          default: ;
        endcase
      end
      else
      begin
        unique case (paddr_in)
          `NDPC_OFF_CTRL: s_nxt.prdata = s_r.ctrl;
          `NDPC_OFF_ADDR1: s_nxt.prdata = s_r.addr1;
          `NDPC_OFF_ADDR2: s_nxt.prdata = {24'h000000, s_r.addr2};
          `NDPC_OFF_STAT: s_nxt.prdata = {29'h0, s_r.rb_s, s_r.err, s_r.busy};
          `NDPC_OFF_RESULT: s_nxt.prdata = {16'h0000, s_r.result};
          default: s_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    // byte currently addressed; un-protect invert bit rides in bit 0 of the
    // first cycle only for 24h, the device ignores it for 23h
    unique case (s_r.aidx)
      3'd0: ab = s_r.addr1[7:0];
      3'd1: ab = s_r.addr1[15:8];
      3'd2: ab = s_r.addr1[23:16];
      3'd3: ab = s_r.addr1[31:24];
      default: ab = s_r.addr2;
    endcase
    if ((op == NDPC_OP_UNP_HI) && (s_r.aidx == 3'd0))
    begin
      ab[0] = s_r.ctrl[`NDPC_CTRL_INV_BIT];
    end
    // tail command of two-part sequences; both planes share the type
    unique case (op)
      NDPC_OP_PROG_MID: ctail = `NDPC_CMD_PROG_MID;
      NDPC_OP_PROG_END: ctail = `NDPC_CMD_PROG_END;
      NDPC_OP_CACHE_END: ctail = `NDPC_CMD_CACHE_END;
      NDPC_OP_ERASE_MID: ctail = `NDPC_CMD_ERASE_MID;
      NDPC_OP_ERASE_END: ctail = `NDPC_CMD_ERASE_END;
      default: ctail = 8'h00;
    endcase
    unique case (s_r.st)
      ST_IDLE: ;
      ST_CMD1:
      begin
        cyc_kind = (op == NDPC_OP_DATA) ? NDPC_LANE_DAT : NDPC_LANE_CMD;
        cyc_byte = (op != NDPC_OP_DATA) ? {8'h00, first_cmd(op)} :
                   x16 ? s_r.ctrl[`NDPC_CTRL_DAT_LSB +: 16] :
                   {8'h00, s_r.ctrl[`NDPC_CTRL_DAT_LSB +: 8]};
        if (cyc_done)
        begin
          s_nxt.acnt = addr_cycles(op);
          s_nxt.aidx = 3'd0;
          s_nxt.go = 1'b1;
          if (op == NDPC_OP_DATA)
          begin
            s_nxt.go = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.st = ST_IDLE;
          end
          else if (addr_cycles(op) != 3'd0)
          begin
            s_nxt.st = ST_ADDR;
          end
          else if ((op == NDPC_OP_STATUS) || (op == NDPC_OP_STAT_ENH))
          begin
            s_nxt.st = ST_READ;
          end
          else
          begin
            s_nxt.st = ST_WAIT;
            s_nxt.go = 1'b0;
            s_nxt.wcnt = 16'h0000;
          end
        end
      end
      ST_ADDR:
      begin
        // word bus keeps io15..8 low on address cycles
        cyc_kind = NDPC_LANE_ADR;
        cyc_byte = {8'h00, ab};
        if (cyc_done)
        begin
          s_nxt.aidx = s_r.aidx + 3'd1;
          s_nxt.acnt = s_r.acnt - 3'd1;
          s_nxt.go = 1'b1;
          if (s_r.acnt == 3'd1)
          begin
            if (op == NDPC_OP_PSTAT)
            begin
              s_nxt.st = ST_READ;
            end
            else if (ctail != 8'h00)
            begin
              s_nxt.st = ST_CMD2;
            end
            else
            begin
              // 85h leaves the data load open for OP_DATA bytes; 23h and 24h end here
              s_nxt.go = 1'b0;
              s_nxt.st = ST_IDLE;
              s_nxt.busy = (op == NDPC_OP_UNP_LO) || (op == NDPC_OP_UNP_HI) ?
                           1'b0 : 1'b0;
            end
          end
          // program sequences pause for data before the tail command
          if ((s_r.acnt == 3'd1) && (first_cmd(op) == `NDPC_CMD_PROG))
          begin
            s_nxt.go = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.st = ST_IDLE;
            s_nxt.pend = ctail;
          end
        end
      end
      ST_CMD2:
      begin
        cyc_kind = NDPC_LANE_CMD;
        cyc_byte = {8'h00, s_r.resume ? s_r.pend : ctail};
        if (cyc_done)
        begin
          s_nxt.st = ST_WAIT;
          s_nxt.wcnt = 16'h0000;
          s_nxt.pend = 8'h00;
        end
      end
      ST_READ:
      begin
        cyc_kind = NDPC_LANE_RD;
        if (cyc_done)
        begin
          // protect status: bit2 unprotected, bits1:0 solid flags
          s_nxt.result = cyc_rd;
          s_nxt.busy = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      default:
      begin
        // wait for rb# high; busy windows of 1 us and 3 us finish here
        s_nxt.wcnt = s_r.wcnt + 16'h0001;
        if ((s_r.wcnt > 16'h0003) && s_r.rb_s)
        begin
          s_nxt.busy = 1'b0;
          s_nxt.st = ST_IDLE;
          // after a closed load the new order starts at its first command
          if (s_r.resume)
          begin
            s_nxt.busy = 1'b1;
            s_nxt.st = ST_CMD1;
            s_nxt.go = 1'b1;
            s_nxt.resume = 1'b0;
          end
        end
        else if (s_r.wcnt == `NDPC_WAIT_LIMIT)
        begin
          s_nxt.resume = 1'b0;
          s_nxt.err = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
    // a program tail resumes when software issues any order other than OP_DATA or NDPC_OP_RAND_IN;
    // that path sends the tail from CMD2; an idle state with go set restarts at CMD1 here
    if ((s_r.st == ST_IDLE) && s_r.go)
    begin
      s_nxt.st = ST_CMD1;
    end
  end
  // ==========================================================================
  // register all state
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_r <= '{st: ST_IDLE, ctrl: `NDPC_CTRL_RST, addr1: 32'h0, addr2: 8'h00,
               acnt: 3'd0, aidx: 3'd0, busy: 1'b0, err: 1'b0, go: 1'b0,
               result: 16'h0000, wcnt: 16'h0000, rb_m: 1'b1, rb_s: 1'b1,
               pready: 1'b0, prdata: 32'h0, wp_n: 1'b0, pend: 8'h00, resume: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  // bus cycle engine
  ndpc_cycle u_cycle (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .go_in(s_r.go),
    .kind_in(cyc_kind),
    .byte_in(cyc_byte),
    .done_out(cyc_done),
    .rd_out(cyc_rd),
    .cle_out(cyc_cle),
    .ale_out(cyc_ale),
    .we_n_out(cyc_we),
    .re_n_out(cyc_re),
    .io_o_out(cyc_io),
    .io_oe_out(cyc_io_oe),
    .io_i_in(io_i_in)
  );
  // outputs come straight from flops, except pslverr and ce# which are tied low
  assign prdata_out = s_r.prdata;
  assign pready_out = s_r.pready;
  assign pslverr_out = 1'b0;
  assign ce_n_out = 1'b0;
  assign cle_out = cyc_cle;
  assign ale_out = cyc_ale;
  assign we_n_out = cyc_we;
  assign re_n_out = cyc_re;
  assign wp_n_out = s_r.wp_n;
  assign io_o_out = cyc_io;
  assign io_oe_out = cyc_io_oe;
  // ==========================================================================
  // assertions
  sequence seq_tail_sent;
    (s_r.st == ST_CMD2) && cyc_done;
  endsequence
  apb_answer_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb answer late");
  inv_bit_hi_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (s_r.st == ST_ADDR) && (op == NDPC_OP_UNP_HI) && (s_r.aidx == 3'd0) |->
    cyc_byte[0] == s_r.ctrl[`NDPC_CTRL_INV_BIT])
    else $error("invert bit not driven with upper bound");
  addr_hi_zero_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (s_r.st == ST_ADDR) |-> cyc_byte[15:8] == 8'h00)
    else $error("upper address byte not low");
  logic busy_q;
  assign busy_q = s_r.busy;
  tail_wait_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    seq_tail_sent |=> (s_r.st == ST_WAIT) && busy_q)
    else $error("no busy wait after tail command");
  solid_wp_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (s_r.st == ST_CMD1) && (op == NDPC_OP_SOLID) |-> wp_n_out)
    else $error("write protect low during solid command");
  erase_tail_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (s_r.st == ST_CMD2) && !s_r.resume && (op == NDPC_OP_ERASE_MID) |->
    cyc_byte[7:0] == 8'hD1)
    else $error("wrong erase tail");
  prog_tail_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (s_r.st == ST_ADDR) && cyc_done && (s_r.acnt == 3'd1) && (op == NDPC_OP_CACHE_END) |=>
    s_r.pend == 8'h15)
    else $error("wrong cache tail");
  read_done_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (s_r.st == ST_READ) && cyc_done |=> !s_r.busy && (s_r.result == $past(cyc_rd)))
    else $error("status byte not captured");
endmodule : ndpc_ctrl
`default_nettype wire

// ### logic/ndpc_consts.svh
// ndpc_consts.svh: offsets, field positions, reset values, commands and timing counts
// assumes: included by the controller files, 20 MHz clock (50 ns period)
`ifndef NDPC_CONSTS_SVH
`define NDPC_CONSTS_SVH
// ==========================================================================
// apb register byte offsets
`define NDPC_OFF_CTRL 12'h000
`define NDPC_OFF_ADDR1 12'h004
`define NDPC_OFF_ADDR2 12'h008
`define NDPC_OFF_DATA 12'h00C
`define NDPC_OFF_STAT 12'h010
`define NDPC_OFF_RESULT 12'h014
// ctrl fields: [3:0] opcode, [4] invert bit, [5] word-wide bus, [15:8] write data ([23:8] on a word bus)
`define NDPC_CTRL_OP_LSB 0
`define NDPC_CTRL_INV_BIT 4
`define NDPC_CTRL_X16_BIT 5
`define NDPC_CTRL_DAT_LSB 8
// status fields
`define NDPC_STAT_BUSY_BIT 0
`define NDPC_STAT_ERR_BIT 1
`define NDPC_STAT_RB_BIT 2
// reset values
`define NDPC_CTRL_RST 32'h0000_0000
// ==========================================================================
// nand command bytes
`define NDPC_CMD_PROG 8'h80
`define NDPC_CMD_PROG_MID 8'h11
`define NDPC_CMD_PROG_END 8'h10
`define NDPC_CMD_CACHE_END 8'h15
`define NDPC_CMD_RAND_IN 8'h85
`define NDPC_CMD_ERASE 8'h60
`define NDPC_CMD_ERASE_MID 8'hD1
`define NDPC_CMD_ERASE_END 8'hD0
`define NDPC_CMD_UNP_LO 8'h23
`define NDPC_CMD_UNP_HI 8'h24
`define NDPC_CMD_PROTECT 8'h2A
`define NDPC_CMD_SOLID 8'h2C
`define NDPC_CMD_PSTAT 8'h7A
`define NDPC_CMD_STATUS 8'h70
`define NDPC_CMD_STAT_ENH 8'h78
`define NDPC_STAT_PROT_FAIL 8'h60
// ==========================================================================
// timing: bus strobe half-cycle and busy windows
`define NDPC_STROBE_CYC 4'h1
`define NDPC_DUAL_BUSY_NS 1000
`define NDPC_PROT_BUSY_NS 3000
`define NDPC_CLK_NS 50
`define NDPC_DUAL_BUSY_CYC (`NDPC_DUAL_BUSY_NS / `NDPC_CLK_NS)
`define NDPC_PROT_BUSY_CYC (`NDPC_PROT_BUSY_NS / `NDPC_CLK_NS)
// rb# must be seen high within this many cycles of entering the wait before it counts as a fault
`define NDPC_WAIT_LIMIT 16'hFFFF
`endif

// ### logic/ndpc_pkg.sv
// ndpc_pkg.sv: types shared by the nand protect/dual-plane controller
// assumes: nothing beyond a standard sv toolchain
`default_nettype none
package ndpc_pkg;
  // ==========================================================================
  // software opcodes
  typedef enum logic [3:0] {
    NDPC_OP_NONE = 4'h0,
    NDPC_OP_PROG_MID = 4'h1,   // 80h addr data.. 11h
    NDPC_OP_PROG_END = 4'h2,   // 80h addr data.. 10h
    NDPC_OP_CACHE_END = 4'h3,  // 80h addr data.. 15h
    NDPC_OP_RAND_IN = 4'h4,    // 85h col data..
    NDPC_OP_ERASE_MID = 4'h5,  // 60h addr D1h
    NDPC_OP_ERASE_END = 4'h6,  // 60h addr D0h
    NDPC_OP_UNP_LO = 4'h7,
    NDPC_OP_UNP_HI = 4'h8,
    NDPC_OP_PROTECT = 4'h9,
    NDPC_OP_SOLID = 4'hA,
    NDPC_OP_PSTAT = 4'hB,
    NDPC_OP_STATUS = 4'hC,
    NDPC_OP_STAT_ENH = 4'hD,
    NDPC_OP_DATA = 4'hE        // one more data byte
  } ndpc_op_e;
  // byte-lane kinds on the nand bus
  typedef enum logic [1:0] {
    NDPC_LANE_CMD = 2'h0,
    NDPC_LANE_ADR = 2'h1,
    NDPC_LANE_DAT = 2'h2,
    NDPC_LANE_RD = 2'h3
  } ndpc_lane_e;
endpackage : ndpc_pkg
`default_nettype wire

// ### logic/ndpc_cycle.sv
// ndpc_cycle.sv: drives one command, address, data or read cycle on the nand bus
// assumes: async nand pins, one strobe phase per NDPC_STROBE_CYC+1 clocks, rb# synced
`default_nettype none
`include "ndpc_consts.svh"
module ndpc_cycle
  import ndpc_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // request
  input wire logic go_in,
  input wire ndpc_lane_e kind_in,
  input wire logic [15:0] byte_in,
  output logic done_out,
  output logic [15:0] rd_out,
  // nand pins
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic [15:0] io_o_out,
  output logic io_oe_out,
  input wire logic [15:0] io_i_in
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0] ph;  // 0 idle, 1 strobe low, 2 strobe high
    logic [3:0] cnt;
    logic cle, ale, we_n, re_n, oe, done;
    logic [15:0] dout, rd;
  } ndpc_cyc_s;
  ndpc_cyc_s s_r, s_nxt;
  // io samples are only taken on the clock after re# has been low a full phase,
  // so the pins have long settled; they stay async only in name
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.ph)
      2'd0:
      begin
        if (go_in)
        begin
          s_nxt.ph = 2'd1;
          s_nxt.cnt = `NDPC_STROBE_CYC;
          s_nxt.cle = (kind_in == NDPC_LANE_CMD);
          s_nxt.ale = (kind_in == NDPC_LANE_ADR);
          s_nxt.oe = (kind_in != NDPC_LANE_RD);
          s_nxt.dout = byte_in;
          s_nxt.we_n = (kind_in == NDPC_LANE_RD);
          s_nxt.re_n = (kind_in != NDPC_LANE_RD);
        end
      end
      2'd1:
      begin
        // strobe low phase; rising edge latches on the device
        if (s_r.cnt == 4'h0)
        begin
          if (!s_r.re_n)
          begin
            s_nxt.rd = io_i_in;
          end
          s_nxt.we_n = 1'b1;
          s_nxt.re_n = 1'b1;
          s_nxt.ph = 2'd2;
          s_nxt.cnt = `NDPC_STROBE_CYC;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      default:
      begin
        // hold data and latches through the high phase
        if (s_r.cnt == 4'h0)
        begin
          s_nxt.ph = 2'd0;
          s_nxt.cle = 1'b0;
          s_nxt.ale = 1'b0;
          s_nxt.oe = 1'b0;
          s_nxt.done = 1'b1;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
    endcase
  end
  // register the state
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_r <= '{ph: 2'd0, cnt: 4'h0, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
               oe: 1'b0, done: 1'b0, dout: 16'h0000, rd: 16'h0000};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign done_out = s_r.done;
  assign rd_out = s_r.rd;
  assign cle_out = s_r.cle;
  assign ale_out = s_r.ale;
  assign we_n_out = s_r.we_n;
  assign re_n_out = s_r.re_n;
  assign io_o_out = s_r.dout;
  assign io_oe_out = s_r.oe;
endmodule : ndpc_cycle
`default_nettype wire

// ### test/ndpc_flash.sv
// ndpc_flash.sv: behavioural x8 nand device, dual-plane and block protection only
// assumes: one chip on the host pins, protection strap fixed by a parameter
`default_nettype none
module ndpc_flash #(
  parameter bit STRAP = 1'b1
) (
  // host pins
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic wp_n_in,
  input wire logic [15:0] io_in,
  // device outputs
  output var logic [15:0] io_out,
  output var logic rb_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // state, one unprotected flag per block
  logic [255:0] unp_r = '0; // all start protected
  logic solid_r = 1'b0;
  logic inv_r = 1'b0;
  logic [7:0] cmd_r = 8'h00, prv_r = 8'h00, cur_r = 8'h00, lo_r = 8'h00;
  logic [7:0] out_r = 8'h00, st_r = 8'hE0;
  int n_r = 0;
  int bt = 0;
  event kick;
  // released bus shows the inverse, so a late sample cannot pass
  assign io_out = re_n_in ? ~{8'h00, out_r} : {8'h00, out_r};
  initial rb_n_out = 1'b1;
  // busy window, started by the tail commands 11h, D1h, 10h, 15h and D0h
  always @(kick)
  begin
    rb_n_out = 1'b0;
    #(bt) rb_n_out = 1'b1;
  end
  // commands and addresses latched on the write strobe
  always @(posedge we_n_in)
    if (cle_in)
    begin
      cmd_r = io_in[7:0];
      n_r = 0;
      if (cmd_r == 8'h2A && STRAP && !solid_r) unp_r = '0;
      if (cmd_r == 8'h2C && STRAP && wp_n_in) solid_r = 1'b1;
      if (cmd_r == 8'h70 || cmd_r == 8'h78) out_r = st_r;
      if (cmd_r == 8'h11 || cmd_r == 8'hD1)
      begin
        bt = 800; // short busy
        -> kick;
      end
      if (cmd_r inside {8'h10, 8'h15, 8'hD0})
      begin
        // both planes written or erased together
        st_r = (STRAP && !unp_r[prv_r]) ? 8'h60 : 8'hE0;
        bt = (st_r == 8'h60) ? 2500 : 2000;
        -> kick;
      end
    end
    else if (ale_in)
    begin
      prv_r = cur_r;
      cur_r = io_in[7:0];
      n_r++;
      if (n_r == 1 && cmd_r == 8'h24) inv_r = io_in[0];
      if (n_r == 3 && cmd_r == 8'h23) lo_r = prv_r;
      if (n_r == 3 && cmd_r == 8'h7A) out_r = {5'h00, unp_r[prv_r], !solid_r, solid_r};
      if (n_r == 3 && cmd_r == 8'h24 && STRAP && !solid_r)
        for (int b = 0; b < 256; b++)
          if (((b >= lo_r) && (b <= prv_r)) != inv_r) unp_r[b] = 1'b1;
    end
endmodule : ndpc_flash
`default_nettype wire

// ### test/testbench.sv
// testbench.sv: apb-driven checks of the nand controller against a device model
// assumes: ndpc_ctrl and ndpc_flash compiled first, x8 bus
`default_nettype none
`include "ndpc_consts.svh"
module testbench
  import ndpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // pins and bookkeeping
  logic mclk_in = 0, arst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic pready_out, cle_out, ale_out, we_n_out, re_n_out, wp_n_out, io_oe_out, rb_n_in;
  logic [15:0] io_o_out, io_i_in, fio;
  int n_mismatch = 0, checks = 0, seed = 2;
  logic [7:0] exp_q[$], msk_q[$];
  always #25 mclk_in = ~mclk_in;
  assign io_i_in = io_oe_out ? io_o_out : fio;
  ndpc_ctrl u_dut (.mclk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out(), .ce_n_out(), .cle_out, .ale_out,
    .we_n_out, .re_n_out, .wp_n_out, .io_o_out, .io_oe_out, .io_i_in, .rb_n_in);
  ndpc_flash u_mem (.cle_in(cle_out), .ale_in(ale_out), .we_n_in(we_n_out),
    .re_n_in(re_n_out), .wp_n_in(wp_n_out), .io_in(io_i_in), .io_out(fio),
    .rb_n_out(rb_n_in));
  // ==========================================
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int t;
    t = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1 && ++t < 50);
    if (t >= 50) n_mismatch++;
    q = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask : apb
  // order one operation, wait for idle, optionally note the result
  task automatic op(input ndpc_op_e o, input logic [31:0] a, input logic i,
    input logic [7:0] e, input logic [7:0] m);
    logic [31:0] q;
    int t;
    t = 0;
    apb(1'b1, `NDPC_OFF_ADDR1, a, q);
    apb(1'b1, `NDPC_OFF_CTRL, {8'h00, a[15:0], 3'b000, i, o}, q);
    do apb(1'b0, `NDPC_OFF_STAT, 32'h0, q); while (q[0] !== 1'b0 && ++t < 400);
    if (t >= 400) n_mismatch++;
    if (m != 8'h00)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, `NDPC_OFF_RESULT, 32'h0, q);
    end
  endtask : op
  // monitor: oldest note against each result read
  always @(posedge mclk_in)
    if (pready_out === 1'b1 && paddr_in == `NDPC_OFF_RESULT && exp_q.size() > 0)
      chk(prdata_out[7:0] & msk_q.pop_front(), exp_q.pop_front());
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // ==========================================
  // main sequence
  initial
  begin
    logic [31:0] q;
    repeat (12) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(posedge mclk_in);
    apb(1'b1, `NDPC_OFF_ADDR2, 32'h0, q);
    op(NDPC_OP_PSTAT, 32'h0300, 0, 8'h02, 8'h07);
    op(NDPC_OP_UNP_LO, 32'h0201, 0, 8'h00, 8'h00);
    op(NDPC_OP_UNP_HI, 32'h0500, 0, 8'h00, 8'h00);
    op(NDPC_OP_PSTAT, 32'h0500, 0, 8'h06, 8'h07);
    op(NDPC_OP_PSTAT, 32'h0200, 0, 8'h06, 8'h07);
    op(NDPC_OP_PSTAT, 32'h0600, 0, 8'h02, 8'h07);
    op(NDPC_OP_UNP_LO, 32'h0A00, 0, 8'h00, 8'h00);
    op(NDPC_OP_UNP_HI, 32'hFA00, 1, 8'h00, 8'h00);
    op(NDPC_OP_PSTAT, 32'hFB00, 0, 8'h06, 8'h07);
    op(NDPC_OP_PSTAT, 32'h0B00, 0, 8'h02, 8'h07);
    $display("test range unprotect done");
    op(NDPC_OP_ERASE_MID, 32'h0B00, 0, 8'h00, 8'h00);
    op(NDPC_OP_ERASE_END, 32'h0B40, 0, 8'h00, 8'h00);
    op(NDPC_OP_STATUS, 32'h0, 0, 8'h60, 8'hFF);
    $display("test protected erase done");
    op(NDPC_OP_PROG_MID, 32'h0300_0000, 0, 8'h00, 8'h00);
    repeat (3) op(NDPC_OP_DATA, $random(seed) & 32'hFF, 0, 8'h00, 8'h00);
    op(NDPC_OP_RAND_IN, 32'h0010, 0, 8'h00, 8'h00);
    op(NDPC_OP_DATA, $random(seed) & 32'hFF, 0, 8'h00, 8'h00);
    op(NDPC_OP_PROG_END, 32'h0340_0000, 0, 8'h00, 8'h00);
    op(NDPC_OP_STATUS, 32'h0, 0, 8'hE0, 8'hFF);
    op(NDPC_OP_STAT_ENH, 32'h0, 0, 8'hE0, 8'hFF);
    op(NDPC_OP_PROG_MID, 32'h0300_0000, 0, 8'h00, 8'h00);
    op(NDPC_OP_DATA, $random(seed) & 32'hFF, 0, 8'h00, 8'h00);
    op(NDPC_OP_CACHE_END, 32'h0340_0000, 0, 8'h00, 8'h00);
    op(NDPC_OP_STATUS, 32'h0, 0, 8'hE0, 8'hFF);
    $display("test dual-plane program done");
    op(NDPC_OP_PROTECT, 32'h0, 0, 8'h00, 8'h00);
    op(NDPC_OP_PSTAT, 32'h0300, 0, 8'h02, 8'h07);
    op(NDPC_OP_UNP_LO, 32'h0500, 0, 8'h00, 8'h00);
    op(NDPC_OP_UNP_HI, 32'h0500, 0, 8'h00, 8'h00);
    chk({7'h00, wp_n_out}, 8'h01);
    op(NDPC_OP_SOLID, 32'h0, 0, 8'h00, 8'h00);
    op(NDPC_OP_PROTECT, 32'h0, 0, 8'h00, 8'h00);
    op(NDPC_OP_PSTAT, 32'h0500, 0, 8'h05, 8'h07);
    op(NDPC_OP_UNP_LO, 32'h0600, 0, 8'h00, 8'h00);
    op(NDPC_OP_UNP_HI, 32'h0600, 0, 8'h00, 8'h00);
    op(NDPC_OP_PSTAT, 32'h0600, 0, 8'h01, 8'h07);
    op(NDPC_OP_ERASE_MID, 32'h0600, 0, 8'h00, 8'h00);
    op(NDPC_OP_ERASE_END, 32'h0640, 0, 8'h00, 8'h00);
    op(NDPC_OP_STATUS, 32'h0, 0, 8'h60, 8'hFF);
    $display("test solid lock done");
    results();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #2000000;
    n_mismatch++;
    results();
  end
endmodule : testbench
`default_nettype wire
